// [adc_host_pkg.sv]
// Constants and types shared by the video converter host controller.
package adc_host_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FIFO_DEPTH = 16;
   // Least start pulse width, rounded up to whole cycles.
   localparam int unsigned START_MIN_NS = 15;
   localparam int unsigned START_CYC = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Least spacing between start leading edges, rounded up.
   localparam int unsigned SPACING_NS = 50;
   localparam int unsigned SPACING_CYC = (SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 4;
   localparam logic [CNT_W-1:0] START_CNT = CNT_W'(START_CYC);
   localparam logic [CNT_W-1:0] SPACING_CNT = CNT_W'(SPACING_CYC);
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   // Interface variant, fixed at build time.
   typedef enum logic
   {
      VARIANT_ECL = 1'b0,
      VARIANT_TTL = 1'b1
   } variant_t;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_PULSE = 2'b01,
      ST_GAP = 2'b10
   } start_state_t;
   // Offset binary zero code of bipolar variants.
   localparam logic [DATA_W-1:0] BIPOLAR_ZERO = 8'h80;
endpackage : adc_host_pkg

// [adc_host_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module adc_host_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire logic push = in_valid && in_ready;
   wire logic pop = out_valid && out_ready;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];

   always_ff @(posedge sys_clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : adc_host_fifo
`default_nettype wire

// [adc_host_ctrl.sv]
// Host controller that starts video conversions and captures results.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - ECL: start is a low-going pulse of at least 15 ns.
// - TTL: start is a high-going pulse of at least 15 ns.
// - ECL: complementary start drive is optional; we drive it for noise immunity.
// - Start leading edges are spaced at least 50 ns apart.
module adc_host_ctrl
   import adc_host_pkg::*;
#(
   parameter variant_t VARIANT = VARIANT_TTL,
   parameter bit BIPOLAR = 1'b0
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic conv_req,
   output logic conv_busy,
   output logic start_p,
   output logic start_n,
   input wire logic eoc_pin,
   input wire logic [DATA_W-1:0] data_pin,
   output logic res_valid,
   input wire logic res_ready,
   output logic [DATA_W-1:0] res_data,
   output logic overflow
);
   start_state_t st_q;
   start_state_t st_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic pulse_q;
   logic start_n_q;
   logic busy_q;
   logic ovf_q;
   logic [2:0] eoc_s_q;
   logic eoc_prev_q;
   logic [DATA_W-1:0] d1_q;
   logic [DATA_W-1:0] d2_q;
   logic [DATA_W-1:0] d3_q;
   logic fifo_ready;
   logic fifo_valid;
   logic [DATA_W-1:0] fifo_data;
   logic res_valid_q;
   logic [DATA_W-1:0] res_data_q;

   // Normalise the end pulse so that active is high whatever the variant.
   function automatic logic eoc_active(input logic lvl);
      return (VARIANT == VARIANT_ECL) ? ~lvl : lvl;
   endfunction : eoc_active

   // The end level counts once the second and third stages agree.
   wire logic eoc_stable = (eoc_s_q[1] == eoc_s_q[2]);
   wire logic eoc_level = eoc_active(eoc_s_q[2]);
   // Trailing edge of the end pulse marks valid data.
   wire logic eoc_fall = eoc_stable && eoc_prev_q && !eoc_level;
   // Sign bit flipped to give two's complement on bipolar parts.
   wire logic [DATA_W-1:0] word = BIPOLAR ? (d3_q ^ BIPOLAR_ZERO) : d3_q;
   // New starts are refused while the result FIFO is full.
   wire logic take = (st_q == ST_IDLE) && conv_req && fifo_ready;
   // The output stage refills whenever it is empty or being drained.
   wire logic fifo_pop = !res_valid_q || res_ready;

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_IDLE:
         begin
            if (take)
            begin
               st_d = ST_PULSE;
               cnt_d = START_CNT - CNT_ONE;
            end
         end
         ST_PULSE:
         begin
            // Pulse held for the least width before release.
            if (cnt_q == CNT_ZERO)
            begin
               st_d = ST_GAP;
               cnt_d = SPACING_CNT - START_CNT - CNT_ONE;
            end
            else
            begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         ST_GAP:
         begin
            // Next start waits out the spacing.
            if (cnt_q == CNT_ZERO)
            begin
               st_d = ST_IDLE;
            end
            else
            begin
               cnt_d = cnt_q - CNT_ONE;
            end
         end
         default:
         begin
            st_d = ST_IDLE;
            cnt_d = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_q <= ST_IDLE;
         cnt_q <= CNT_ZERO;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
      end
   end

   // Active-high start on TTL, inverted on ECL; complement driven.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pulse_q <= (VARIANT == VARIANT_ECL);
         start_n_q <= (VARIANT != VARIANT_ECL);
         busy_q <= 1'b0;
      end
      else
      begin
         pulse_q <= (st_d == ST_PULSE) ^ (VARIANT == VARIANT_ECL);
         start_n_q <= (st_d != ST_PULSE) ^ (VARIANT == VARIANT_ECL);
         busy_q <= (st_d != ST_IDLE);
      end
   end

   // Data is sampled with the end pulse so skew has settled.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         eoc_s_q <= {3{(VARIANT == VARIANT_ECL)}};
         eoc_prev_q <= 1'b0;
         d1_q <= '0;
         d2_q <= '0;
         d3_q <= '0;
         ovf_q <= 1'b0;
      end
      else
      begin
         eoc_s_q <= {eoc_s_q[1:0], eoc_pin};
         d1_q <= data_pin;
         d2_q <= d1_q;
         d3_q <= d2_q;
         if (eoc_stable)
         begin
            eoc_prev_q <= eoc_level;
         end
         // A result lost to a full FIFO is flagged, sticky until reset.
         if (eoc_fall && !fifo_ready)
         begin
            ovf_q <= 1'b1;
         end
      end
   end

   adc_host_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .in_valid(eoc_fall),
      .in_ready(fifo_ready),
      .in_data(word),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // Output stage keeps the result port straight from flip-flops.
   // It adds one word of buffering behind the FIFO, at no loss of throughput.
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         res_valid_q <= 1'b0;
         res_data_q <= '0;
      end
      else if (fifo_pop)
      begin
         res_valid_q <= fifo_valid;
         res_data_q <= fifo_data;
      end
   end

   assign start_p = pulse_q;
   assign start_n = start_n_q;
   assign conv_busy = busy_q;
   assign res_valid = res_valid_q;
   assign res_data = res_data_q;
   assign overflow = ovf_q;
endmodule : adc_host_ctrl
`default_nettype wire

// [adc_host_ctrl_props.sv]
// Checker for the converter host controller ports.
`timescale 1ns/1ps
`default_nettype none
module adc_host_chk
   import adc_host_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic conv_req,
   input wire logic conv_busy,
   input wire logic start_p,
   input wire logic start_n,
   input wire logic res_valid,
   input wire logic res_ready,
   input wire logic [DATA_W-1:0] res_data,
   input wire logic overflow
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_start_width: assert property ($rose(start_p) |-> start_p ##1 start_p ##1 !start_p)
      else $error("start pulse width wrong");
   a_start_compl: assert property (start_n != start_p)
      else $error("start pins not complementary");
   a_start_space: assert property ($rose(start_p) |=> (!$rose(start_p)) [*4])
      else $error("start edges too close");
   a_start_cause: assert property ($rose(start_p) |-> $past(conv_req))
      else $error("start without request");
   a_busy_span: assert property ($rose(start_p) |-> conv_busy [*5])
      else $error("busy shorter than spacing");
   a_word_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
      else $error("result word dropped or changed");
   a_ovf_sticky: assert property (overflow |=> overflow)
      else $error("overflow flag cleared");
endmodule : adc_host_chk
bind adc_host_ctrl adc_host_chk chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .conv_req(conv_req),
   .conv_busy(conv_busy), .start_p(start_p), .start_n(start_n), .res_valid(res_valid),
   .res_ready(res_ready), .res_data(res_data), .overflow(overflow));
`default_nettype wire

// [adc_dev_model.sv]
// Behavioural model of the video converter seen by the host.
`timescale 1ns/1ps
`default_nettype none
module adc_dev_model
   import adc_host_pkg::*;
(
   input wire logic start_p,
   input wire logic start_n,
   input wire logic [DATA_W-1:0] code,
   output logic eoc_pin,
   output logic [DATA_W-1:0] data_pin
);
   initial eoc_pin = 1'b0;
   initial data_pin = 8'h5a;
   task automatic convert(input logic [DATA_W-1:0] v);
      #55;
      data_pin = v;
      eoc_pin = 1'b1;
      #20;
      eoc_pin = 1'b0;
   endtask : convert
   // Fixed unipolar TTL.
   // Conversions overlap, so each one runs as its own process.
   always @(posedge start_p)
   begin
      fork
         convert(code);
      join_none
   end
endmodule : adc_dev_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the converter host controller.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import adc_host_pkg::*;
;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic conv_req = 1'b0;
   logic res_ready = 1'b0;
   logic conv_busy, start_p, start_n, eoc_pin, res_valid, overflow;
   logic [DATA_W-1:0] data_pin, res_data;
   logic [DATA_W-1:0] code = 8'h00;
   logic [DATA_W-1:0] exp_q[$];
   logic [DATA_W-1:0] corner[5] = '{8'h00, 8'h80, 8'hff, 8'hc0, 8'h01};
   int mismatches = 0;
   int total_checks = 0;
   int nstart = 0;
   int npop = 0;
   always #5 sys_clk = ~sys_clk;
   adc_host_ctrl dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .conv_req(conv_req),
      .conv_busy(conv_busy), .start_p(start_p), .start_n(start_n), .eoc_pin(eoc_pin),
      .data_pin(data_pin), .res_valid(res_valid), .res_ready(res_ready),
      .res_data(res_data), .overflow(overflow));
   adc_dev_model dev_u (.start_p(start_p), .start_n(start_n), .code(code),
      .eoc_pin(eoc_pin), .data_pin(data_pin));
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   always @(posedge start_p)
   begin
      exp_q.push_back(code);
      nstart++;
   end
   always @(posedge sys_clk)
      if (sys_rst === 1'b0 && res_valid === 1'b1 && res_ready === 1'b1)
      begin
         check(16'(res_data), 16'(exp_q.pop_front()));
         npop++;
      end
   // A stalled run overfills the buffer; the FIFO and the output stage keep 17 words.
   task automatic run(input int cyc, input bit stall);
      int s;
      s = nstart;
      npop = 0;
      conv_req = 1'b1;
      repeat (cyc)
      begin
         tick();
         res_ready = stall ? 1'b0 : 1'($urandom);
         code = 8'($urandom);
      end
      conv_req = 1'b0;
      res_ready = 1'b0;
      repeat (20) tick();
      res_ready = 1'b1;
      repeat (40) tick();
      s = nstart - s;
      check(16'(npop), 16'((s > 17) ? 17 : s));
      check(16'(overflow), 16'(s > 17));
      exp_q.delete();
      $display("run done, starts=%0d", s);
   endtask : run
   initial
   begin
      void'($urandom(81612));
      repeat (3) tick();
      sys_rst = 1'b0;
      check(16'(res_valid), 16'h0000);
      res_ready = 1'b1;
      foreach (corner[i])
      begin
         code = corner[i];
         conv_req = 1'b1;
         tick();
         conv_req = 1'b0;
         check(16'(start_p), 16'h0001);
         check(16'(start_n), 16'h0000);
         check(16'(conv_busy), 16'h0001);
         repeat (15) tick();
      end
      check(16'(nstart), 16'h0005);
      $display("corner codes done");
      run(60, 1'b0);
      run(150, 1'b1);
      end_sim();
   end
   initial
   begin
      #20000;
      mismatches++;
      end_sim();
   end
endmodule : testbench
`default_nettype wire
